/* File: include/awd_regs.svh */
// register indices, field positions, reset values and timing counts of the window detector
`ifndef AWD_REGS_SVH
`define AWD_REGS_SVH
// Function
// - upper limit low byte, resets to ones
// - lower limit high byte, read-write, resets ones
// - lower limit low byte, read-write, resets ones
// - lower limit is high:low sixteen bits
// - compare justified twelve-bit results against limits
// - conversion lasts at least sixteen converter clocks
// - sticky window flag, polled or interrupting
// - limit order selects inside or outside
// - justify bit places result left or right

// word indices; byte address is four times the index
`define AWD_IDX_CFG 10'h0BC
`define AWD_IDX_RES_L 10'h0BE
`define AWD_IDX_RES_H 10'h0BF
`define AWD_IDX_UL_L 10'h0C4
`define AWD_IDX_UL_H 10'h0C5
`define AWD_IDX_LL_H 10'h0C6
`define AWD_IDX_LL_L 10'h0C7
`define AWD_IDX_IRQ_STS 10'h0C8
`define AWD_IDX_IRQ_MSK 10'h0C9
`define AWD_IDX_CTL 10'h0E8

// reset values
`define AWD_RST_LIMIT 8'hFF
`define AWD_RST_CFG 8'h60
`define AWD_RST_CTL 8'h00

// control register fields
`define AWD_CTL_EN 7
`define AWD_CTL_TRACK 6
`define AWD_CTL_DONE 5
`define AWD_CTL_BUSY 4
`define AWD_CTL_MODE_HI 3
`define AWD_CTL_MODE_LO 2
`define AWD_CTL_WIN 1
`define AWD_CTL_LJUST 0

// configuration register fields
`define AWD_CFG_DIV_HI 7
`define AWD_CFG_DIV_LO 5
`define AWD_CFG_GAIN_HI 2
`define AWD_CFG_GAIN_LO 0

// interrupt status and mask bits
`define AWD_IRQ_DONE 0
`define AWD_IRQ_WIN 1
`define AWD_IRQ_W 2

// converter clocks per conversion
`define AWD_CONV_SAR_CLKS 5'h10

`endif

/* File: include/awd_pkg.sv */
// types of the window detector
package awd_pkg;

	typedef enum logic {AWD_IDLE, AWD_CONV} awd_state_t;

	typedef enum logic [1:0] {
		AWD_START_SW = 2'h0,
		AWD_START_RSV1 = 2'h1,
		AWD_START_RSV2 = 2'h2,
		AWD_START_TMR = 2'h3
	} awd_start_t;

	typedef enum logic [3:0] {
		AWD_R_NONE,
		AWD_R_CFG,
		AWD_R_RES_L,
		AWD_R_RES_H,
		AWD_R_UL_L,
		AWD_R_UL_H,
		AWD_R_LL_H,
		AWD_R_LL_L,
		AWD_R_IRQ_STS,
		AWD_R_IRQ_MSK,
		AWD_R_CTL
	} awd_reg_t;

endpackage

/* File: include/awd_cmp_if.sv */
// link between the sequencer and the window comparator
`timescale 1ns/1ns
interface awd_cmp_if;
	logic sample_valid;
	logic [11:0] sample;
	logic left_justify;
	logic [15:0] upper_limit;
	logic [15:0] lower_limit;
	logic done;
	logic hit;
	logic [15:0] result;

	modport ctl (
		output sample_valid,
		output sample,
		output left_justify,
		output upper_limit,
		output lower_limit,
		input done,
		input hit,
		input result
	);

	modport cmp (
		input sample_valid,
		input sample,
		input left_justify,
		input upper_limit,
		input lower_limit,
		output done,
		output hit,
		output result
	);
endinterface

/* File: core/awd_cmp.sv */
// justifies each conversion result and tests it against the window limits
`timescale 1ns/1ns
module awd_cmp import awd_pkg::*; (
	input logic pclk,
	input logic presetn,
	awd_cmp_if.cmp cmp_bus
);

	logic [15:0] word_d;
	logic [15:0] word_q;
	logic hit_d;
	logic hit_q;
	logic done_d;
	logic done_q;

	// lower above upper means inside the window, otherwise outside
	function automatic logic window_hit(input logic [15:0] v, input logic [15:0] gt, input logic [15:0] lt);
		if (lt > gt) begin
			window_hit = (v > gt) && (v < lt);
		end else begin
			window_hit = (v > gt) || (v < lt);
		end
	endfunction

	always_comb begin
		word_d = word_q;
		hit_d = 1'b0;
		done_d = cmp_bus.sample_valid;
		if (cmp_bus.sample_valid) begin
			if (cmp_bus.left_justify) begin
				word_d = {cmp_bus.sample, 4'h0};
			end else begin
				word_d = {4'h0, cmp_bus.sample};
			end
			hit_d = window_hit(word_d, cmp_bus.upper_limit, cmp_bus.lower_limit);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_q <= 16'h0000;
			hit_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			word_q <= word_d;
			hit_q <= hit_d;
			done_q <= done_d;
		end
	end

	assign cmp_bus.result = word_q;
	assign cmp_bus.hit = hit_q;
	assign cmp_bus.done = done_q;

endmodule // awd_cmp

/* File: core/awd_top.sv */
// window limit detector: apb registers, conversion sequencer and interrupt
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "awd_regs.svh"

module awd_top import awd_pkg::*; (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic [11:0] sar_data,
	input logic timer_overflow,
	output logic converter_enable,
	output logic conv_busy,
	output logic irq
);

	// ************************************************************
	// declarations
	// ************************************************************

	awd_cmp_if cmp_bus ();

	awd_reg_t sel_d;
	awd_reg_t sel_q;
	logic [7:0] rd_byte;
	logic [7:0] rd_d;
	logic [7:0] rd_q;
	logic setup;
	logic access;
	logic wr_en;
	logic [7:0] wbyte;

	logic [7:0] ul_l_d;
	logic [7:0] ul_l_q;
	logic [7:0] ul_h_d;
	logic [7:0] ul_h_q;
	logic [7:0] ll_l_d;
	logic [7:0] ll_l_q;
	logic [7:0] ll_h_d;
	logic [7:0] ll_h_q;

	logic [2:0] div_d;
	logic [2:0] div_q;
	logic [2:0] gain_d;
	logic [2:0] gain_q;
	logic en_d;
	logic en_q;
	logic track_d;
	logic track_q;
	logic [1:0] mode_d;
	logic [1:0] mode_q;
	logic ljust_d;
	logic ljust_q;

	awd_state_t state_d;
	awd_state_t state_q;
	logic [3:0] pre_d;
	logic [3:0] pre_q;
	logic [4:0] sar_cnt_d;
	logic [4:0] sar_cnt_q;
	logic sar_tick;
	logic start;
	logic sv_d;
	logic sv_q;
	logic [11:0] smp_d;
	logic [11:0] smp_q;

	logic [`AWD_IRQ_W-1:0] sts_d;
	logic [`AWD_IRQ_W-1:0] sts_q;
	logic [`AWD_IRQ_W-1:0] msk_d;
	logic [`AWD_IRQ_W-1:0] msk_q;
	logic [`AWD_IRQ_W-1:0] sts_set;
	logic [`AWD_IRQ_W-1:0] sts_clr;

	// ************************************************************
	// helpers
	// ************************************************************

	// word index to register select; the two low address bits are ignored
	function automatic awd_reg_t decode_reg(input logic [11:0] addr);
		case (addr[11:2])
			`AWD_IDX_CFG: decode_reg = AWD_R_CFG;
			`AWD_IDX_RES_L: decode_reg = AWD_R_RES_L;
			`AWD_IDX_RES_H: decode_reg = AWD_R_RES_H;
			`AWD_IDX_UL_L: decode_reg = AWD_R_UL_L;
			`AWD_IDX_UL_H: decode_reg = AWD_R_UL_H;
			`AWD_IDX_LL_H: decode_reg = AWD_R_LL_H;
			`AWD_IDX_LL_L: decode_reg = AWD_R_LL_L;
			`AWD_IDX_IRQ_STS: decode_reg = AWD_R_IRQ_STS;
			`AWD_IDX_IRQ_MSK: decode_reg = AWD_R_IRQ_MSK;
			`AWD_IDX_CTL: decode_reg = AWD_R_CTL;
			default: decode_reg = AWD_R_NONE;
		endcase
	endfunction

	// converter clock period minus one, in system clocks
	function automatic logic [3:0] sar_last(input logic [2:0] code);
		case (code)
			3'h0: sar_last = 4'h0;
			3'h1: sar_last = 4'h1;
			3'h2: sar_last = 4'h3;
			3'h3: sar_last = 4'h7;
			default: sar_last = 4'hF;
		endcase
	endfunction

	// ************************************************************
	// apb slave
	// ************************************************************

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = access;
	assign pslverr = access && (sel_q == AWD_R_NONE);
	assign wr_en = access && pwrite && (sel_q != AWD_R_NONE);
	assign wbyte = pwdata[7:0];
	assign prdata = {24'h000000, rd_q};

	// read view of every register
	always_comb begin
		rd_byte = 8'h00;
		case (decode_reg(paddr))
			AWD_R_CFG: rd_byte = {div_q, 2'h0, gain_q};
			AWD_R_RES_L: rd_byte = cmp_bus.result[7:0];
			AWD_R_RES_H: rd_byte = cmp_bus.result[15:8];
			AWD_R_UL_L: rd_byte = ul_l_q;
			AWD_R_UL_H: rd_byte = ul_h_q;
			AWD_R_LL_H: rd_byte = ll_h_q;
			AWD_R_LL_L: rd_byte = ll_l_q;
			AWD_R_IRQ_STS: rd_byte = {6'h00, sts_q};
			AWD_R_IRQ_MSK: rd_byte = {6'h00, msk_q};
			AWD_R_CTL: rd_byte = {en_q, track_q, sts_q[`AWD_IRQ_DONE], conv_busy, mode_q,
				sts_q[`AWD_IRQ_WIN], ljust_q};
			default: rd_byte = 8'h00;
		endcase
	end

	// select and read data are caught in the setup cycle
	always_comb begin
		sel_d = sel_q;
		rd_d = rd_q;
		if (setup) begin
			sel_d = decode_reg(paddr);
			rd_d = rd_byte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= AWD_R_NONE;
			rd_q <= 8'h00;
		end else begin
			sel_q <= sel_d;
			rd_q <= rd_d;
		end
	end

	// ************************************************************
	// limit and control registers
	// ************************************************************

	always_comb begin
		ul_l_d = ul_l_q;
		ul_h_d = ul_h_q;
		ll_l_d = ll_l_q;
		ll_h_d = ll_h_q;
		div_d = div_q;
		gain_d = gain_q;
		en_d = en_q;
		track_d = track_q;
		mode_d = mode_q;
		ljust_d = ljust_q;
		msk_d = msk_q;
		if (wr_en) begin
			case (sel_q)
				AWD_R_UL_L: ul_l_d = wbyte;
				AWD_R_UL_H: ul_h_d = wbyte;
				AWD_R_LL_H: ll_h_d = wbyte;
				AWD_R_LL_L: ll_l_d = wbyte;
				AWD_R_CFG: begin
					div_d = wbyte[`AWD_CFG_DIV_HI:`AWD_CFG_DIV_LO];
					gain_d = wbyte[`AWD_CFG_GAIN_HI:`AWD_CFG_GAIN_LO];
				end
				AWD_R_CTL: begin
					en_d = wbyte[`AWD_CTL_EN];
					track_d = wbyte[`AWD_CTL_TRACK];
					mode_d = wbyte[`AWD_CTL_MODE_HI:`AWD_CTL_MODE_LO];
					ljust_d = wbyte[`AWD_CTL_LJUST];
				end
				AWD_R_IRQ_MSK: msk_d = wbyte[`AWD_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ul_l_q <= `AWD_RST_LIMIT;
			ul_h_q <= `AWD_RST_LIMIT;
			ll_h_q <= `AWD_RST_LIMIT;
			ll_l_q <= `AWD_RST_LIMIT;
			div_q <= 3'(`AWD_RST_CFG >> `AWD_CFG_DIV_LO);
			gain_q <= 3'h0;
			en_q <= 1'(`AWD_RST_CTL >> `AWD_CTL_EN);
			track_q <= 1'b0;
			mode_q <= 2'h0;
			ljust_q <= 1'b0;
			msk_q <= '0;
		end else begin
			ul_l_q <= ul_l_d;
			ul_h_q <= ul_h_d;
			ll_h_q <= ll_h_d;
			ll_l_q <= ll_l_d;
			div_q <= div_d;
			gain_q <= gain_d;
			en_q <= en_d;
			track_q <= track_d;
			mode_q <= mode_d;
			ljust_q <= ljust_d;
			msk_q <= msk_d;
		end
	end

	// ************************************************************
	// conversion sequencer
	// ************************************************************

	// a start while busy or disabled is ignored
	always_comb begin
		start = 1'b0;
		if (en_q && (state_q == AWD_IDLE) && !sv_q) begin
			if (mode_q == AWD_START_SW) begin
				start = wr_en && (sel_q == AWD_R_CTL) && wbyte[`AWD_CTL_BUSY];
			end else if (mode_q == AWD_START_TMR) begin
				start = timer_overflow;
			end
		end
	end

	assign sar_tick = (pre_q == sar_last(div_q));

	always_comb begin
		state_d = state_q;
		pre_d = pre_q;
		sar_cnt_d = sar_cnt_q;
		sv_d = 1'b0;
		smp_d = smp_q;
		case (state_q)
			AWD_IDLE: begin
				pre_d = 4'h0;
				sar_cnt_d = 5'h00;
				if (start) begin
					state_d = AWD_CONV;
				end
			end
			AWD_CONV: begin
				if (!en_q) begin
					state_d = AWD_IDLE;
				end else if (sar_tick) begin
					pre_d = 4'h0;
					sar_cnt_d = sar_cnt_q + 5'h01;
					if (sar_cnt_q == `AWD_CONV_SAR_CLKS - 5'h01) begin
						sv_d = 1'b1;
						smp_d = sar_data;
						state_d = AWD_IDLE;
					end
				end else begin
					pre_d = pre_q + 4'h1;
				end
			end
			default: state_d = AWD_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= AWD_IDLE;
			pre_q <= 4'h0;
			sar_cnt_q <= 5'h00;
			sv_q <= 1'b0;
			smp_q <= 12'h000;
		end else begin
			state_q <= state_d;
			pre_q <= pre_d;
			sar_cnt_q <= sar_cnt_d;
			sv_q <= sv_d;
			smp_q <= smp_d;
		end
	end

	assign conv_busy = (state_q == AWD_CONV) || sv_q;
	assign converter_enable = en_q;

	// ************************************************************
	// window comparator
	// ************************************************************

	assign cmp_bus.sample_valid = sv_q;
	assign cmp_bus.sample = smp_q;
	assign cmp_bus.left_justify = ljust_q;
	assign cmp_bus.upper_limit = {ul_h_q, ul_l_q};
	assign cmp_bus.lower_limit = {ll_h_q, ll_l_q};

	awd_cmp u_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.cmp_bus(cmp_bus.cmp)
	);

	// ************************************************************
	// interrupt flags
	// ************************************************************

	assign sts_set[`AWD_IRQ_DONE] = cmp_bus.done;
	assign sts_set[`AWD_IRQ_WIN] = cmp_bus.done && cmp_bus.hit;

	// write one to clear; a set in the same cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < `AWD_IRQ_W; gi++) begin : g_sts
			assign sts_clr[gi] = wr_en && (sel_q == AWD_R_IRQ_STS) && wbyte[gi];
			assign sts_d[gi] = sts_set[gi] || (sts_q[gi] && !sts_clr[gi]);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_q <= '0;
		end else begin
			sts_q <= sts_d;
		end
	end

	assign irq = |(sts_q & msk_q);

endmodule // awd_top

/* File: verif/awd_top_monitor.sv */
// concurrent checks on the ports of the window detector
`timescale 1ns/1ns
`include "awd_regs.svh"

module awd_top_monitor import awd_pkg::*; (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic [11:0] sar_data,
	input logic timer_overflow,
	input logic converter_enable,
	input logic conv_busy,
	input logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus write seen one cycle late, the only cause other than a finished conversion
	logic wr_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= psel && penable && pwrite;
		end
	end
	a_busy_min_len: assert property ($rose(conv_busy) |-> conv_busy[*8] ##1 conv_busy[*8])
		else $error("conversion shorter than sixteen clocks");
	a_busy_max_len: assert property ($rose(conv_busy) |-> ##[16:300] !conv_busy)
		else $error("conversion never ends");
	a_start_needs_enable: assert property ($rose(conv_busy) |-> $past(converter_enable))
		else $error("conversion started while disabled");
	a_irq_rise_cause: assert property ($rose(irq) |-> wr_q || ($past(conv_busy, 2) && !$past(conv_busy)))
		else $error("interrupt rose without cause");
	a_irq_fall_cause: assert property ($fell(irq) |-> wr_q)
		else $error("sticky interrupt dropped by itself");
	a_ready_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_upper_mapped: assert property (psel && penable && paddr[11:2] == `AWD_IDX_UL_L |-> !pslverr)
		else $error("limit register flagged as error");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	a_unmapped_error: assert property (psel && penable && paddr[11:2] == 10'h000 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	c_irq_up: cover property ($rose(irq));
	c_conv_done: cover property ($fell(conv_busy));
	c_bus_error: cover property (pslverr);
endmodule // awd_top_monitor

/* File: verif/awd_top_bench.sv */
// self-checking bench of the window detector
`timescale 1ns/1ns
`include "awd_regs.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, e, a); end end

module awd_top_bench import awd_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, timer_overflow = 0;
	logic [11:0] paddr = 0, sar_data = 0;
	logic [31:0] pwdata = 0, prdata, seed = 32'h48B79FF0;
	logic pready, pslverr, converter_enable, conv_busy, irq, irq_exp = 0;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	typedef struct {string nm; logic [33:0] e;} awd_note_t;
	awd_note_t notes[$];
	logic [44:0] tab[6] = '{{1'b0, 16'h0100, 16'h0200, 12'h180}, {1'b0, 16'h0100, 16'h0200, 12'h100},
		{1'b0, 16'h0200, 16'h0100, 12'h050}, {1'b0, 16'h0200, 16'h0100, 12'h150},
		{1'b1, 16'h1000, 16'h2000, 12'h180}, {1'b1, 16'h2000, 16'h1000, 12'h0FF}};
	logic [9:0] lim[4] = '{`AWD_IDX_UL_H, `AWD_IDX_UL_L, `AWD_IDX_LL_H, `AWD_IDX_LL_L};
	always #2 pclk = ~pclk;
	awd_top awd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sar_data(sar_data), .timer_overflow(timer_overflow), .converter_enable(converter_enable),
		.conv_busy(conv_busy), .irq(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic hitf(input logic [15:0] v, g, l);
		return (l > g) ? (v > g && v < l) : (v > g || v < l);
	endfunction
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'h0}; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0; penable <= 0;
	endtask
	task automatic rd(input logic [9:0] idx, input logic [8:0] e, input string nm);
		notes.push_back('{nm, {irq_exp, e[8], 24'h0, e[7:0]}});
		apb(0, idx, 8'h00);
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ************
	// read watcher
	// ************
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && notes.size() > 0) begin
			awd_note_t t;
			t = notes.pop_front();
			`CHK(t.nm, t.e, {irq, pslverr, prdata})
		end
		cyc++;
		if (cyc == 20000) begin n_mismatch++; finish_test(); end
	end
	// ************
	// main sequence
	// ************
	initial begin
		logic lj;
		logic [15:0] g, l, v;
		logic [11:0] d;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 4; i++) rd(lim[i], 9'h0FF, "limit_reset");
		rd(`AWD_IDX_CFG, 9'h060, "cfg_reset");
		rd(`AWD_IDX_CTL, 9'h000, "ctl_reset");
		rd(10'h000, 9'h100, "unmapped");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			apb(1, lim[i], seed[7:0]);
			rd(lim[i], {1'b0, seed[7:0]}, "limit_rw");
		end
		for (int i = 0; i < 7; i++) begin
			seed = lfsr(seed);
			{lj, g, l, d} = (i < 6) ? tab[i] : {seed[0], seed[31:16], seed[15:0], seed[27:16]};
			apb(1, `AWD_IDX_IRQ_MSK, (i == 4) ? 8'h00 : 8'h03);
			apb(1, `AWD_IDX_CFG, {i[2:0], 5'h00});
			apb(1, `AWD_IDX_UL_H, g[15:8]);
			apb(1, `AWD_IDX_UL_L, g[7:0]);
			apb(1, `AWD_IDX_LL_H, l[15:8]);
			apb(1, `AWD_IDX_LL_L, l[7:0]);
			sar_data <= d;
			// enable first: a start is only taken while the enable bit already stands
			apb(1, `AWD_IDX_CTL, (i == 5) ? {7'h46, lj} : {7'h40, lj});
			if (i == 5) begin
				timer_overflow <= 1;
				@(posedge pclk);
				timer_overflow <= 0;
			end else begin
				apb(1, `AWD_IDX_CTL, {7'h48, lj});
			end
			for (int n = 0; n < 400 && (n < 3 || conv_busy); n++) @(posedge pclk);
			v = lj ? {d, 4'h0} : {4'h0, d};
			irq_exp = (i != 4);
			rd(`AWD_IDX_RES_L, {1'b0, v[7:0]}, "result_low");
			rd(`AWD_IDX_RES_H, {1'b0, v[15:8]}, "result_high");
			rd(`AWD_IDX_IRQ_STS, {7'h00, hitf(v, g, l), 1'b1}, "status");
			rd(`AWD_IDX_CTL, {5'h0A, (i == 5) ? 2'h3 : 2'h0, hitf(v, g, l), lj}, "ctl_flags");
			apb(1, `AWD_IDX_IRQ_STS, 8'h03);
			irq_exp = 0;
			rd(`AWD_IDX_IRQ_STS, 9'h000, "status_clear");
		end
		repeat (2) @(posedge pclk);
		if (notes.size() > 0) n_mismatch++;
		finish_test();
	end
endmodule // awd_top_bench

bind awd_top awd_top_monitor awd_top_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sar_data(sar_data), .timer_overflow(timer_overflow),
	.converter_enable(converter_enable), .conv_busy(conv_busy), .irq(irq));
